//--- pkg/foc_consts.svh
/*
  Constants of the flow output channels: register offsets, control
  field positions, reset values, current and frequency set points and
  timing counts. Assumes a 125 MHz clock and a 32-bit APB register bus.
*/
`ifndef FOC_CONSTS_SVH
`define FOC_CONSTS_SVH

// Register byte offsets
`define FOC_ADDR_CTRL     8'h00
`define FOC_ADDR_CUTOFF   8'h04
`define FOC_ADDR_LOOP_LO  8'h08
`define FOC_ADDR_LOOP_HI  8'h0c
`define FOC_ADDR_ALARM_UA 8'h10
`define FOC_ADDR_VPP      8'h14
`define FOC_ADDR_PWIDTH   8'h18
`define FOC_ADDR_FREQ_LO  8'h1c
`define FOC_ADDR_FREQ_HI  8'h20
`define FOC_ADDR_STATUS   8'h24
`define FOC_ADDR_SETPT    8'h28
`define FOC_ADDR_PENDING  8'h2c

// Control register fields
`define FOC_CTRL_CUT_EN    0
`define FOC_CTRL_LOOP_MODE 2:1
`define FOC_CTRL_ALARM_EN  3
`define FOC_CTRL_ALARM_SEL 5:4
`define FOC_CTRL_PULSE_EN  6
`define FOC_CTRL_OUT_FREQ  7
`define FOC_CTRL_ACCT      9:8
`define FOC_CTRL_POL_NEG   10
`define FOC_CTRL_LOGIN     11
`define FOC_CTRL_LOOP_EN   12
`define FOC_CTRL_W         13

// Reset values
`define FOC_CTRL_RST   13'h0000
`define FOC_WORD_RST   32'h0000_0000
`define FOC_PWIDTH_RST 9'h001

// Loop set points in microamperes
`define FOC_UA_4MA  16'h0fa0
`define FOC_UA_20MA 16'h4e20
`define FOC_UA_SPAN 16'h3e80
`define FOC_UA_LOW  16'h0ea6
`define FOC_UA_HIGH 16'h5460

// Frequency points in millihertz
`define FOC_FREQ_2KHZ 21'h1e8480
`define FOC_FREQ_SPAN 21'h1e8098
`define FOC_FREQ_MIN  21'h000064
// Phase step per cycle is f_mhz * 2^32 / 125e9, scaled by 2^20
`define FOC_PHASE_MUL 38'h00_0000_8cbd
`define FOC_PHASE_SH  20

// Pulse limits
`define FOC_PEND_MAX   16'hffff
`define FOC_PWIDTH_MIN 9'h001
`define FOC_PWIDTH_MAX 9'h1f3

// Timing: one millisecond in ns, clock period in ns
`define FOC_MS_TIME_NS 1000000
`define FOC_CLK_NS     8
`define FOC_MS_CYCLES  (`FOC_MS_TIME_NS / `FOC_CLK_NS)

// Divider width
`define FOC_DIV_W 56

`endif

//--- pkg/foc_pkg.sv
/*
  Types of the flow output channels: mapping, alarm and accounting
  modes and the state codes of both state machines.
  Assumes nothing beyond the constants header.
*/
package foc_pkg;

  typedef enum logic [1:0] {
    FOC_LOOP_NORMAL = 2'h0,
    FOC_LOOP_INVERT = 2'h1,
    FOC_LOOP_MODULO = 2'h2
  } foc_loop_mode_t;

  typedef enum logic [1:0] {
    FOC_ALM_LOW    = 2'h0,
    FOC_ALM_HIGH   = 2'h1,
    FOC_ALM_CUSTOM = 2'h2,
    FOC_ALM_LAST   = 2'h3
  } foc_alarm_sel_t;

  typedef enum logic [1:0] {
    FOC_ACCT_POS = 2'h0,
    FOC_ACCT_NEG = 2'h1,
    FOC_ACCT_MOD = 2'h2
  } foc_acct_t;

  typedef enum logic [2:0] {
    FOC_PS_IDLE = 3'h1,
    FOC_PS_HIGH = 3'h2,
    FOC_PS_GAP  = 3'h4
  } foc_pulse_st_t;

  typedef enum logic [1:0] {
    FOC_DS_IDLE = 2'h1,
    FOC_DS_RUN  = 2'h2
  } foc_div_st_t;

endpackage

//--- pkg/foc_div_if.sv
/*
  Request and answer bundle between the output logic and a divider.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/100ps
`include "foc_consts.svh"
interface foc_div_if;
  logic                   start;
  logic [`FOC_DIV_W-1:0]  num;
  logic [`FOC_DIV_W-1:0]  den;
  logic                   busy;
  logic                   done;
  logic [`FOC_DIV_W-1:0]  quo;
  modport client (output start, num, den, input busy, done, quo);
  modport server (input start, num, den, output busy, done, quo);
endinterface

//--- core/foc_divider.sv
/*
  Unsigned restoring divider, one quotient bit per clock.
  Assumes start only while busy is low; divide by zero gives all ones.
*/
`timescale 1ns/100ps
`include "foc_consts.svh"
module foc_divider (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Request and answer
  foc_div_if.server div
);
  localparam int W = `FOC_DIV_W;
  foc_pkg::foc_div_st_t st_reg;
  logic [W:0]   rem_reg;
  logic [W-1:0] quo_reg;
  logic [W-1:0] den_reg;
  logic [6:0]   cnt_reg;
  logic         done_reg;
  logic [W:0]   rem_sh;
  logic         fits;

  // One shift and trial subtraction per cycle
  assign rem_sh   = {rem_reg[W-1:0], quo_reg[W-1]};
  assign fits     = rem_sh >= {1'b0, den_reg};
  assign div.busy = st_reg == foc_pkg::FOC_DS_RUN;
  assign div.done = done_reg;
  assign div.quo  = quo_reg;

  // Sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg   <= foc_pkg::FOC_DS_IDLE;
      rem_reg  <= '0;
      quo_reg  <= '0;
      den_reg  <= '0;
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      unique case (st_reg)
        foc_pkg::FOC_DS_IDLE: begin
          if (div.start) begin
            rem_reg <= '0;
            quo_reg <= div.num;
            den_reg <= div.den;
            cnt_reg <= 7'(W);
            st_reg  <= foc_pkg::FOC_DS_RUN;
          end
        end
        foc_pkg::FOC_DS_RUN: begin
          rem_reg <= fits ? rem_sh - {1'b0, den_reg} : rem_sh;
          quo_reg <= {quo_reg[W-2:0], fits};
          cnt_reg <= cnt_reg - 7'h01;
          if (cnt_reg == 7'h01) begin
            done_reg <= 1'b1;
            st_reg   <= foc_pkg::FOC_DS_IDLE;
          end
        end
        default: st_reg <= foc_pkg::FOC_DS_IDLE;
      endcase
    end
  end
endmodule

//--- core/foc_top.sv
/*
  Flow output channels: low-flow cutoff, loop set point with alarm
  substitution, and pulse or frequency output with pulse accounting.
  Assumes flow samples from logic on the same clock and an APB master.
*/
`timescale 1ns/100ps
`include "foc_consts.svh"
// Operation
// - Cutoff on: small flow results become zero
// - Loop mapping normal, inverted or absolute
// - Two flow points scale 4 and 20 mA
// - Alarm on and status bad: alarm response
// - Low alarm 3.75 mA, high 21.6 mA
// - Custom alarm drives user current value
// - Last-value alarm freezes pre-alarm set point
// - Pending count over maximum sets saturation
// - Saturation clears after login screen return
// - One pulse per volume-per-pulse accumulated
// - Volume per pulse accepts zero too
// - Pulse width 1 to 499 ms
// - Positive mode: reverse flow cancels pulses
// - Negative mode: forward flow cancels pulses
// - Modulo mode: both directions, separate direction
// - Polarity selectable for pulse output
// - At most 500 Hz with 1 ms width
// - Frequency mode: two flow points, 0.1 Hz floor
// - Direction output forward-active, switches with pulse
module foc_top #(
  parameter int unsigned MS_CYCLES = `FOC_MS_CYCLES
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               arst_n,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Flow samples and device status
  input  wire logic               flow_valid,
  input  wire logic signed [31:0] flow_value,
  input  wire logic               dev_status_ok,
  // Outputs
  output logic      [15:0]        loop_setpoint_ua,
  output logic                    loop_enable,
  output logic                    pulse_out,
  output logic                    pulse_dir,
  output logic                    pulse_count_saturation_flag
);
  localparam int W = `FOC_DIV_W;

  function automatic logic [31:0] foc_abs(input logic [31:0] v);
    return v[31] ? 32'(-v) : v;
  endfunction

  function automatic logic [33:0] foc_mag(input logic [33:0] v);
    return v[33] ? 34'(-v) : v;
  endfunction

  // Reset release through two flops
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rst_sync_reg <= 2'b00;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  logic [`FOC_CTRL_W-1:0] ctrl_reg;
  logic [31:0] cutoff_reg, loop_lo_reg, loop_hi_reg, freq_lo_reg;
  logic [31:0] freq_hi_reg, vpp_reg;
  logic [15:0] alarm_ua_reg, setpt_reg, scaled_reg, hold_reg, pend_reg;
  logic [8:0]  pwidth_reg;
  logic [31:0] prdata_reg;
  logic        sat_reg, login_seen_reg, dir_reg, pout_reg;

  // Control fields
  wire       output_polarity_select = ctrl_reg[`FOC_CTRL_POL_NEG];
  wire       pulse_en = ctrl_reg[`FOC_CTRL_PULSE_EN];
  wire       out_freq = ctrl_reg[`FOC_CTRL_OUT_FREQ];
  wire       login_on = ctrl_reg[`FOC_CTRL_LOGIN];
  wire [1:0] loop_mode = ctrl_reg[`FOC_CTRL_LOOP_MODE];
  wire [1:0] alarm_sel = ctrl_reg[`FOC_CTRL_ALARM_SEL];
  wire [1:0] acct = ctrl_reg[`FOC_CTRL_ACCT];

  // Address decode
  wire sel_ctrl = paddr == `FOC_ADDR_CTRL;
  wire sel_cut  = paddr == `FOC_ADDR_CUTOFF;
  wire sel_llo  = paddr == `FOC_ADDR_LOOP_LO;
  wire sel_lhi  = paddr == `FOC_ADDR_LOOP_HI;
  wire sel_alm  = paddr == `FOC_ADDR_ALARM_UA;
  wire sel_vpp  = paddr == `FOC_ADDR_VPP;
  wire sel_pw   = paddr == `FOC_ADDR_PWIDTH;
  wire sel_flo  = paddr == `FOC_ADDR_FREQ_LO;
  wire sel_fhi  = paddr == `FOC_ADDR_FREQ_HI;
  wire sel_stat = paddr == `FOC_ADDR_STATUS;
  wire sel_spt  = paddr == `FOC_ADDR_SETPT;
  wire sel_pend = paddr == `FOC_ADDR_PENDING;
  wire hit = sel_ctrl | sel_cut | sel_llo | sel_lhi | sel_alm | sel_vpp
           | sel_pw | sel_flo | sel_fhi | sel_stat | sel_spt | sel_pend;
  wire wr_en = psel & penable & pwrite & hit;
  wire alarm = ctrl_reg[`FOC_CTRL_ALARM_EN] & ~dev_status_ok;
  foc_pkg::foc_pulse_st_t pst_reg;
  wire pulse_act = pst_reg == foc_pkg::FOC_PS_HIGH;
  // Width clamped at write, so zero or over-range never reaches timing
  wire [8:0] pw_in = pwdata[8:0] < `FOC_PWIDTH_MIN ? `FOC_PWIDTH_MIN
                   : pwdata[8:0] > `FOC_PWIDTH_MAX ||
                     pwdata[31:9] != 23'h0 ? `FOC_PWIDTH_MAX
                   : pwdata[8:0];

  // Read mux; zero wait states, unmapped address answers with error
  wire [31:0] rd_data =
      sel_ctrl ? 32'(ctrl_reg) : sel_cut ? cutoff_reg
    : sel_llo ? loop_lo_reg : sel_lhi ? loop_hi_reg
    : sel_alm ? 32'(alarm_ua_reg) : sel_vpp ? vpp_reg
    : sel_pw ? 32'(pwidth_reg) : sel_flo ? freq_lo_reg
    : sel_fhi ? freq_hi_reg
    : sel_stat ? {28'h0, alarm, dir_reg, pulse_act, sat_reg}
    : sel_spt ? 32'(setpt_reg) : sel_pend ? 32'(pend_reg)
    : `FOC_WORD_RST;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = prdata_reg;

  // Register writes; read data captured in the setup cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `FOC_CTRL_RST;
      {cutoff_reg, loop_lo_reg, loop_hi_reg} <= {3{`FOC_WORD_RST}};
      {freq_lo_reg, freq_hi_reg, vpp_reg} <= {3{`FOC_WORD_RST}};
      alarm_ua_reg <= `FOC_UA_4MA;
      pwidth_reg   <= `FOC_PWIDTH_RST;
      prdata_reg   <= `FOC_WORD_RST;
    end else begin
      if (psel & ~penable & ~pwrite) prdata_reg <= rd_data;
      if (wr_en & sel_ctrl) ctrl_reg <= pwdata[`FOC_CTRL_W-1:0];
      if (wr_en & sel_cut) cutoff_reg <= pwdata;
      if (wr_en & sel_llo) loop_lo_reg <= pwdata;
      if (wr_en & sel_lhi) loop_hi_reg <= pwdata;
      if (wr_en & sel_alm) alarm_ua_reg <= pwdata[15:0];
      if (wr_en & sel_vpp) vpp_reg <= pwdata;
      if (wr_en & sel_pw) pwidth_reg <= pw_in;
      if (wr_en & sel_flo) freq_lo_reg <= pwdata;
      if (wr_en & sel_fhi) freq_hi_reg <= pwdata;
    end
  end

  // Cutoff stage: compares magnitude, so reverse noise is cut too
  logic [31:0] flow_reg;
  logic        tick_reg;
  wire cut = ctrl_reg[`FOC_CTRL_CUT_EN] &&
             foc_abs(flow_value) < cutoff_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flow_reg <= `FOC_WORD_RST;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= flow_valid;
      if (flow_valid) flow_reg <= cut ? `FOC_WORD_RST : flow_value;
    end
  end

  // Loop mapping and scaling request
  foc_div_if ldiv ();
  foc_div_if fdiv ();
  foc_divider u_ldiv (.clk(clk), .rst_n(rst_n), .div(ldiv.server));
  foc_divider u_fdiv (.clk(clk), .rst_n(rst_n), .div(fdiv.server));
  wire [33:0] flow34 = {{2{flow_reg[31]}}, flow_reg};
  wire [33:0] loop_x =
      loop_mode == foc_pkg::FOC_LOOP_INVERT ? 34'(-flow34)
    : loop_mode == foc_pkg::FOC_LOOP_MODULO ? {2'b00, foc_abs(flow_reg)}
    : flow34;
  wire [33:0] llo34 = {{2{loop_lo_reg[31]}}, loop_lo_reg};
  wire [33:0] ldiff = loop_x - llo34;
  wire [33:0] lspan = {{2{loop_hi_reg[31]}}, loop_hi_reg} - llo34;
  assign ldiv.start = tick_reg & ~ldiv.busy;
  assign ldiv.num = W'(foc_mag(ldiff)) * W'(`FOC_UA_SPAN);
  assign ldiv.den = W'(foc_mag(lspan));

  // Frequency request from the two frequency flow points
  wire [33:0] flo34 = {{2{freq_lo_reg[31]}}, freq_lo_reg};
  wire [33:0] fdiff = flow34 - flo34;
  wire [33:0] fspan = {{2{freq_hi_reg[31]}}, freq_hi_reg} - flo34;
  assign fdiv.start = tick_reg & ~fdiv.busy;
  assign fdiv.num = W'(foc_mag(fdiff)) * W'(`FOC_FREQ_SPAN);
  assign fdiv.den = W'(foc_mag(fspan));

  // Result shaping; sign latched with each request
  logic lneg_reg, fneg_reg;
  logic [20:0] fmhz_reg;
  wire [15:0] lval = lneg_reg && ldiv.quo != '0 ? `FOC_UA_4MA
                   : ldiv.quo >= W'(`FOC_UA_SPAN) ? `FOC_UA_20MA
                   : `FOC_UA_4MA + ldiv.quo[15:0];
  wire [20:0] fval = fneg_reg ? `FOC_FREQ_2KHZ
    : fdiv.quo > W'(`FOC_FREQ_2KHZ - `FOC_FREQ_MIN) ? `FOC_FREQ_MIN
    : `FOC_FREQ_2KHZ - fdiv.quo[20:0];
  wire [15:0] spt_next =
      !alarm ? scaled_reg
    : alarm_sel == foc_pkg::FOC_ALM_LOW ? `FOC_UA_LOW
    : alarm_sel == foc_pkg::FOC_ALM_HIGH ? `FOC_UA_HIGH
    : alarm_sel == foc_pkg::FOC_ALM_CUSTOM ? alarm_ua_reg
    : hold_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {lneg_reg, fneg_reg} <= 2'b00;
      {scaled_reg, hold_reg, setpt_reg} <= {3{`FOC_UA_4MA}};
      fmhz_reg <= `FOC_FREQ_MIN;
    end else begin
      if (ldiv.start) lneg_reg <= ldiff[33] ^ lspan[33];
      if (fdiv.start) fneg_reg <= fdiff[33] ^ fspan[33];
      if (ldiv.done) scaled_reg <= lval;
      if (fdiv.done) fmhz_reg <= fval;
      if (!alarm) hold_reg <= scaled_reg;
      setpt_reg <= spt_next;
    end
  end
  assign loop_setpoint_ua = setpt_reg;
  assign loop_enable = ctrl_reg[`FOC_CTRL_LOOP_EN];

  // Phase accumulator for the frequency output
  logic [16:0] finc_reg;
  logic [31:0] phase_reg;
  wire [37:0] fprod = 38'(fmhz_reg) * `FOC_PHASE_MUL;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      finc_reg  <= '0;
      phase_reg <= '0;
    end else begin
      finc_reg  <= fprod[`FOC_PHASE_SH+16:`FOC_PHASE_SH];
      phase_reg <= pulse_en & out_freq ? phase_reg + 32'(finc_reg) : '0;
    end
  end

  // Volume accounting; acc keeps the remainder between samples
  logic [39:0] acc_reg;
  wire pulse_mode = pulse_en & ~out_freq;
  wire [39:0] flow40 = {{8{flow_reg[31]}}, flow_reg};
  wire [39:0] vpp40  = {8'h00, vpp_reg};
  wire [39:0] contrib =
      acct == foc_pkg::FOC_ACCT_NEG ? 40'(-flow40)
    : acct == foc_pkg::FOC_ACCT_MOD ? {8'h00, foc_abs(flow_reg)}
    : flow40;
  wire has_q  = vpp_reg != `FOC_WORD_RST;
  wire can_up = has_q && $signed(acc_reg) >= $signed(vpp40);
  wire can_dn = has_q && acct != foc_pkg::FOC_ACCT_MOD &&
                $signed(acc_reg) <= $signed(40'(-vpp40));
  wire pend_full = pend_reg == `FOC_PEND_MAX;
  wire start_p = pst_reg == foc_pkg::FOC_PS_IDLE && pulse_mode &&
                 pend_reg != '0;
  wire up  = ~tick_reg & can_up & ~pend_full;
  wire dn  = ~tick_reg & ~can_up & can_dn & ~start_p &&
             pend_reg != '0;
  wire sat_set = ~tick_reg & can_up & pend_full;
  wire [39:0] acc_next = tick_reg ? acc_reg + contrib
                       : up ? acc_reg - vpp40
                       : dn ? acc_reg + vpp40 : acc_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg  <= '0;
      pend_reg <= '0;
    end else if (!pulse_mode) begin
      acc_reg  <= '0;
      pend_reg <= '0;
    end else begin
      acc_reg  <= acc_next;
      pend_reg <= pend_reg + 16'(up) - 16'(dn | start_p);
    end
  end

  // Saturation flag; a new event wins over the screen-return clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sat_reg        <= 1'b0;
      login_seen_reg <= 1'b0;
    end else begin
      login_seen_reg <= sat_reg & login_on;
      if (sat_set) sat_reg <= 1'b1;
      else if (login_seen_reg & ~login_on) sat_reg <= 1'b0;
    end
  end
  assign pulse_count_saturation_flag = sat_reg;

  // Millisecond enable, restarted at each pulse start
  logic [16:0] ms_cnt_reg;
  logic [8:0]  w_cnt_reg;
  wire ms_tick = ms_cnt_reg == 17'(MS_CYCLES - 1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ms_cnt_reg <= '0;
    else if (pst_reg == foc_pkg::FOC_PS_IDLE || ms_tick) ms_cnt_reg <= '0;
    else ms_cnt_reg <= ms_cnt_reg + 17'h00001;
  end

  // Pulse timing: width then a 1 ms gap caps the rate at 500 Hz
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pst_reg   <= foc_pkg::FOC_PS_IDLE;
      w_cnt_reg <= '0;
      dir_reg   <= 1'b1;
    end else begin
      unique case (pst_reg)
        foc_pkg::FOC_PS_IDLE: begin
          w_cnt_reg <= '0;
          if (start_p) begin
            pst_reg <= foc_pkg::FOC_PS_HIGH;
            dir_reg <= ~flow_reg[31];
          end
        end
        foc_pkg::FOC_PS_HIGH: begin
          if (ms_tick) w_cnt_reg <= w_cnt_reg + 9'h001;
          if (ms_tick && w_cnt_reg + 9'h001 == pwidth_reg) begin
            pst_reg <= foc_pkg::FOC_PS_GAP;
          end
        end
        foc_pkg::FOC_PS_GAP: begin
          if (ms_tick) pst_reg <= foc_pkg::FOC_PS_IDLE;
        end
        default: pst_reg <= foc_pkg::FOC_PS_IDLE;
      endcase
    end
  end

  // Output stage with polarity
  wire out_act = out_freq ? pulse_en & phase_reg[31] : pulse_act;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pout_reg <= 1'b0;
    else pout_reg <= out_act ^ output_polarity_select;
  end
  assign pulse_out = pout_reg;
  assign pulse_dir = dir_reg;
endmodule

//--- tb/foc_assertions.sv
/*
  Port checker of the flow output channels.
  Assumes binding to foc_top; settings are shadowed from APB writes.
*/
`timescale 1ns/100ps
`include "foc_consts.svh"
module foc_assertions #(
  parameter int unsigned MS_CYCLES = 20
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // Status and outputs
  input wire logic        dev_status_ok,
  input wire logic [15:0] loop_setpoint_ua,
  input wire logic        pulse_out,
  input wire logic        pulse_dir,
  input wire logic        pulse_count_saturation_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [12:0] ctrl_reg;
  logic [15:0] cust_reg;
  logic [8:0]  pw_reg;
  logic [31:0] on_cnt_reg;
  logic [31:0] off_cnt_reg;
  // Decode of shadowed settings
  wire logic       wr    = psel && penable && pwrite && pready;
  wire logic       act   = pulse_out ^ ctrl_reg[10];
  wire logic       pe    = ctrl_reg[6] && !ctrl_reg[7];
  wire logic       alm   = ctrl_reg[3] && !dev_status_ok;
  wire logic [1:0] sel   = ctrl_reg[5:4];
  wire logic       login = ctrl_reg[11];
  // Shadow taken on the same edge the slave takes writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= `FOC_CTRL_RST;
      cust_reg <= `FOC_UA_4MA;
      pw_reg   <= `FOC_PWIDTH_RST;
    end else if (wr) begin
      if (paddr == `FOC_ADDR_CTRL) ctrl_reg <= pwdata[12:0];
      if (paddr == `FOC_ADDR_ALARM_UA) cust_reg <= pwdata[15:0];
      if (paddr == `FOC_ADDR_PWIDTH) pw_reg <= pwdata[8:0];
    end
  end
  // Run lengths; gap starts full so the first pulse is not flagged
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      on_cnt_reg  <= '0;
      off_cnt_reg <= MS_CYCLES;
    end else begin
      on_cnt_reg  <= act ? on_cnt_reg + 1 : '0;
      off_cnt_reg <= !pe ? MS_CYCLES : (act ? '0 : off_cnt_reg + 1);
    end
  end
  a_alarm_low: assert property (
    (alm && sel == 2'h0)[*2] |-> loop_setpoint_ua == `FOC_UA_LOW)
    else $error("low alarm set point wrong");
  a_alarm_high: assert property (
    (alm && sel == 2'h1)[*2] |-> loop_setpoint_ua == `FOC_UA_HIGH)
    else $error("high alarm set point wrong");
  a_alarm_custom: assert property (
    (alm && sel == 2'h2)[*2] |-> loop_setpoint_ua == cust_reg)
    else $error("custom alarm set point wrong");
  a_alarm_last: assert property (
    (alm && sel == 2'h3)[*3] |-> $stable(loop_setpoint_ua))
    else $error("held set point moved during alarm");
  a_pulse_width: assert property (
    $fell(act) && pe |-> on_cnt_reg == pw_reg * MS_CYCLES)
    else $error("pulse width wrong");
  a_pulse_gap: assert property (
    $rose(act) && pe |-> off_cnt_reg >= MS_CYCLES)
    else $error("pulses too close");
  a_dir_at_start: assert property (
    !$stable(pulse_dir) && pe |=> $rose(act))
    else $error("direction changed outside pulse start");
  a_sat_hold: assert property (
    (pe && !login)[*3] ##0 pulse_count_saturation_flag
      |=> pulse_count_saturation_flag)
    else $error("saturation flag lost on main screen");
  a_sat_clear: assert property (
    (login && !pe) ##1 (!login && !pe)[*3]
      |-> !pulse_count_saturation_flag)
    else $error("saturation flag not cleared");
  c_alarm_last: cover property ((alm && sel == 2'h3)[*3]);
  c_sat_set: cover property ($rose(pulse_count_saturation_flag));
  c_pulse_done: cover property ($fell(act) && pe);
endmodule
bind foc_top foc_assertions #(.MS_CYCLES(MS_CYCLES)) u_foc_assertions (
  .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .dev_status_ok, .loop_setpoint_ua, .pulse_out, .pulse_dir,
  .pulse_count_saturation_flag
);

//--- tb/foc_pulse_counter.sv
/*
  Plant pulse counter watching the pulse and direction outputs.
  Assumes the bench tells it the configured polarity.
*/
`timescale 1ns/100ps
module foc_pulse_counter (
  // Clock and lines
  input wire logic    clk,
  input wire logic    pulse_out,
  input wire logic    pulse_dir,
  input wire logic    pol_neg,
  // Tallies
  output logic [15:0] tot_cnt,
  output logic [15:0] fwd_cnt
);
  logic act_reg = 1'b0;
  wire logic act = pulse_out ^ pol_neg;
  initial tot_cnt = 16'h0000;
  initial fwd_cnt = 16'h0000;
  // Leading edges only; direction read at pulse start
  always @(posedge clk) begin
    act_reg <= act;
    if (act && !act_reg) begin
      tot_cnt <= tot_cnt + 16'h0001;
      fwd_cnt <= fwd_cnt + {15'h0000, pulse_dir};
    end
  end
endmodule

//--- tb/tb_top.sv
/*
  Bench of the flow output channels: APB tasks, flow samples, checks.
  Assumes the checker binds itself and a pulse counter on the far side.
*/
`timescale 1ns/100ps
`include "foc_consts.svh"
module tb_top;
  localparam int unsigned MS = 20; // Short millisecond keeps run brief
  logic               clk = 1'b0;
  logic               arst_n = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic               flow_valid = 1'b0;
  logic signed [31:0] flow_value = 32'sh0;
  logic               dev_status_ok = 1'b1;
  logic               pol_neg = 1'b0;
  logic [31:0]        prdata, rdat;
  logic               pready, pslverr, rerr, loop_enable;
  logic               pulse_out, pulse_dir, pulse_count_saturation_flag;
  logic [15:0]        loop_setpoint_ua, tot_cnt, fwd_cnt;
  int                 error_cnt = 0, tests_run = 0, cyc = 0;
  logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h10, 8'h18, 8'h28, 8'h2c, 8'h30};
  logic [31:0] rv [7] = '{0, 0, 32'hfa0, 1, 32'hfa0, 0, 0};
  logic [31:0] pw [3] = '{0, 499, 500};
  logic [31:0] pe [3] = '{1, 499, 499};
  logic [31:0] lc [6] = '{32'h1000, 32'h1001, 32'h1001, 32'h1002,
                          32'h1004, 32'h1000};
  logic signed [31:0] lf [6] = '{800, 400, 600, -400, -1200, -800};
  logic [15:0] le [6] = '{16'h2ee0, 16'h0fa0, 16'h2710, 16'h1f40,
                          16'h3e80, 16'h0fa0};
  logic [15:0] ae [4] = '{`FOC_UA_LOW, `FOC_UA_HIGH, 16'h1388, 16'h2ee0};

  foc_top #(.MS_CYCLES(MS)) u_foc_top (
    .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .flow_valid, .flow_value, .dev_status_ok,
    .loop_setpoint_ua, .loop_enable, .pulse_out, .pulse_dir,
    .pulse_count_saturation_flag
  );
  foc_pulse_counter u_foc_pulse_counter (
    .clk, .pulse_out, .pulse_dir, .pol_neg, .tot_cnt, .fwd_cnt
  );

  initial forever #4 clk = ~clk;

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Hang guard, above the roughly 70k cycle saturation run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      error_cnt++;
      conclude();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic flow(input logic signed [31:0] v, input int n);
    @(posedge clk);
    flow_valid <= 1'b1;
    flow_value <= v;
    @(posedge clk);
    flow_valid <= 1'b0;
    tick(n);
  endtask

  // Pulse run; polarity settles with pulses off so no false edge counts
  task automatic run(input logic [31:0] c, input logic signed [31:0] a,
                     input logic signed [31:0] b, input int g,
                     input logic [15:0] et, input logic [15:0] ef);
    logic [15:0] t0, f0;
    apb(1'b1, 8'h00, c & 32'hffbf);
    pol_neg <= c[10];
    tick(4);
    chk(pulse_out, c[10]);
    t0 = tot_cnt;
    f0 = fwd_cnt;
    apb(1'b1, 8'h00, c);
    flow(a, g);
    flow(b, 400);
    chk(tot_cnt - t0, et);
    chk(fwd_cnt - f0, ef);
  endtask

  initial begin
    tick(10);
    arst_n <= 1'b1;
    tick(3);
    chk(loop_setpoint_ua, `FOC_UA_4MA);
    chk({pulse_dir, pulse_out, pulse_count_saturation_flag}, 3'h4);
    foreach (ra[i]) begin
      apb(1'b0, ra[i], 0);
      chk(rdat, rv[i]);
      chk(rerr, ra[i] == 8'h30);
    end
    foreach (pw[i]) begin
      apb(1'b1, 8'h18, pw[i]);
      apb(1'b0, 8'h18, 0);
      chk(rdat, pe[i]);
    end
    apb(1'b1, 8'h14, 32'h0098967f);
    apb(1'b0, 8'h14, 0);
    chk(rdat, 32'h0098967f);
    // Cutoff and mapping: 4 mA at flow 0, 20 mA at flow 1600
    apb(1'b1, 8'h04, 500);
    apb(1'b1, 8'h08, 0);
    apb(1'b1, 8'h0c, 1600);
    foreach (lc[i]) begin
      apb(1'b1, 8'h00, lc[i]);
      flow(lf[i], 70);
      chk(loop_setpoint_ua, le[i]);
      chk(loop_enable, 1'b1);
    end
    apb(1'b1, 8'h10, 32'h1388);
    dev_status_ok <= 1'b0;
    foreach (ae[i]) begin
      apb(1'b1, 8'h00, 32'h1000);
      flow(800, 70);
      chk(loop_setpoint_ua, 16'h2ee0);
      apb(1'b1, 8'h00, 32'h1008 + 32'(i) * 32'h10);
      tick(3);
      chk(loop_setpoint_ua, ae[i]);
      flow(400, 70);
      chk(loop_setpoint_ua, ae[i]);
    end
    dev_status_ok <= 1'b1;
    // 2 ms pulses, one per 100 units, rate kept inside the limit
    apb(1'b1, 8'h18, 2);
    apb(1'b1, 8'h14, 100);
    run(32'h1040, 350, 50, 3, 4, 4);
    run(32'h1040, 500, -300, 3, 2, 1);
    run(32'h1140, 400, -600, 3, 2, 0);
    run(32'h1640, 200, -100, 300, 3, 2);
    apb(1'b1, 8'h14, 0);
    run(32'h1040, 500, 0, 3, 0, 0);
    // Saturation needs 65535 pending, one quantum per cycle
    apb(1'b1, 8'h14, 1);
    apb(1'b1, 8'h18, 1);
    apb(1'b1, 8'h00, 32'h1040);
    flow(80000, 0);
    while (pulse_count_saturation_flag !== 1'b1) tick(1);
    tick(100);
    chk(pulse_count_saturation_flag, 1'b1);
    apb(1'b0, 8'h24, 0);
    chk(rdat[0], 1'b1);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h00, 32'h800);
    apb(1'b1, 8'h00, 32'h0);
    tick(4);
    chk(pulse_count_saturation_flag, 1'b0);
    conclude();
  end
endmodule
